//--- common/apm_ch_if.sv
// Link between the command logic and one pulse channel
`timescale 1ns/1ps
interface apm_ch_if;
  logic               start;
  logic signed [31:0] target;
  logic [31:0]        rate;
  logic               abort;
  logic               fwd_lim;
  logic               rev_lim;
  logic               busy;
  logic               pulse;
  logic               dir;
  logic               done_ev;
  logic               fault_ev;
  logic signed [31:0] pos;
  modport ctl (output start, target, rate, abort, fwd_lim, rev_lim,
               input busy, pulse, dir, done_ev, fault_ev, pos);
  modport ch  (input start, target, rate, abort, fwd_lim, rev_lim,
               output busy, pulse, dir, done_ev, fault_ev, pos);
endinterface

//--- common/apm_pkg.sv
// Constants and types for the absolute pulse positioning block
package apm_pkg;
  // ----------------------------------------
  // Clock and channel figures
  // ----------------------------------------
  localparam int unsigned CLK_HZ   = 200_000_000;
  localparam int unsigned HALF_CLK = CLK_HZ / 2;
  localparam int unsigned NCH      = 4;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_TARGET   = 8'h04;
  localparam logic [7:0] REG_RATE     = 8'h08;
  localparam logic [7:0] REG_CMD      = 8'h0C;
  localparam logic [7:0] REG_LIMIT    = 8'h10;
  localparam logic [7:0] REG_STOP     = 8'h14;
  localparam logic [7:0] REG_STATUS   = 8'h18;
  localparam logic [7:0] REG_IRQ_STAT = 8'h1C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h20;
  localparam logic [7:0] REG_POS0     = 8'h24;
  localparam logic [7:0] REG_STEP     = 8'h04;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_RUN    = 0;
  localparam int CTRL_WIDE   = 1;
  localparam int CTRL_ADPT   = 2;
  localparam int CTRL_ADPT2  = 3;
  localparam int CTRL_CH2FIT = 4;
  localparam int CTRL_W      = 5;
  localparam int CMD_CH_LSB  = 0;
  localparam int CMD_DIR_LSB = 4;
  localparam int CMD_ACT     = 8;
  localparam int LIM_REV_LSB = 4;
  localparam int ST_DONE     = 0;
  localparam int ST_FAULT    = 1;
  localparam int ST_BUSY_LSB = 4;
  localparam int ST_ACTV_LSB = 8;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_FAULT   = 1;
  localparam int SHORT_W     = 16;
  // ----------------------------------------
  // Channel states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_STOP = 3'b100
  } apm_state_t;
endpackage

//--- hw/apm_channel.sv
// One pulse and direction generator with its position counter
`timescale 1ns/1ps
module apm_channel #(
  parameter int unsigned HALF = apm_pkg::HALF_CLK
) (
  input wire logic clk,   // System clock
  input wire logic rstn,  // Sync reset, low
  input wire logic ce,    // Clock enable
  apm_ch_if.ch     chif   // Command side
);
  apm_pkg::apm_state_t state;
  logic signed [31:0]  tgt;
  logic signed [31:0]  pos;
  logic [31:0]         rate_l;
  logic [32:0]         acc;
  logic [32:0]         sum;
  logic                pulse;
  logic                dir;
  logic                lim_hit;
  logic                stop_lim;
  logic                tick;
  logic                at_tgt;
  logic                stop_end;

  assign sum      = acc + {1'b0, rate_l};
  assign tick     = sum >= 33'(HALF);
  assign at_tgt   = pulse && tick && (pos == tgt);
  assign stop_end = !pulse || tick;
  // R17: limit in travel direction
  assign lim_hit  = dir ? chif.fwd_lim : chif.rev_lim;
  // R12: busy while producing pulses
  assign chif.busy  = state != apm_pkg::ST_IDLE;
  assign chif.pulse = pulse;
  assign chif.dir   = dir;
  assign chif.pos   = pos;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state    <= apm_pkg::ST_IDLE;
      tgt      <= '0;
      rate_l   <= '0;
      dir      <= 1'b0;
      stop_lim <= 1'b0;
    end else if (ce) begin
      unique case (state)
        apm_pkg::ST_IDLE: begin
          // R15: operands taken at activation only
          if (chif.start) begin
            tgt    <= chif.target;
            rate_l <= chif.rate;
            // R14: forward if target above position
            dir    <= chif.target > pos;
            if (chif.target != pos) begin
              state <= apm_pkg::ST_RUN;
            end
          end
        end
        apm_pkg::ST_RUN: begin
          if (at_tgt) begin
            state <= apm_pkg::ST_IDLE;
          end else if (chif.abort || lim_hit) begin
            // R16: removal winds down without done
            stop_lim <= lim_hit;
            state    <= apm_pkg::ST_STOP;
          end
        end
        apm_pkg::ST_STOP: begin
          if (stop_end) begin
            state <= apm_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pulse train and position
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      acc   <= '0;
      pulse <= 1'b0;
      pos   <= '0;
    end else if (ce) begin
      if (state == apm_pkg::ST_IDLE) begin
        acc   <= '0;
        pulse <= 1'b0;
      end else begin
        acc <= tick ? sum - 33'(HALF) : sum;
        if (tick && pulse) begin
          pulse <= 1'b0;
        end else if (tick && state == apm_pkg::ST_RUN) begin
          pulse <= 1'b1;
          pos   <= dir ? pos + 32'sd1 : pos - 32'sd1;
        end
      end
    end
  end

  // ----------------------------------------
  // End events
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      chif.done_ev  <= 1'b0;
      chif.fault_ev <= 1'b0;
    end else if (ce) begin
      // R18: done when position meets target
      chif.done_ev <= (state == apm_pkg::ST_RUN && at_tgt) ||
                      (state == apm_pkg::ST_IDLE && chif.start &&
                       chif.target == pos);
      chif.fault_ev <= state == apm_pkg::ST_STOP && stop_end && stop_lim;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_busy_pulse;
    @(posedge clk) disable iff (!rstn || !ce)
    pulse |-> chif.busy;
  endproperty
  a_busy_pulse: assert property (p_busy_pulse) // R12
    else $error("pulse seen while channel idle");

  property p_dir_pick;
    @(posedge clk) disable iff (!rstn || !ce)
    (state == apm_pkg::ST_IDLE && chif.start && chif.target != pos)
      |=> (dir == ($past(chif.target) > $past(pos)));
  endproperty
  a_dir_pick: assert property (p_dir_pick) // R14
    else $error("wrong direction chosen");

  property p_hold_ops;
    @(posedge clk) disable iff (!rstn || !ce)
    (state != apm_pkg::ST_IDLE) |=> $stable(tgt) && $stable(rate_l);
  endproperty
  a_hold_ops: assert property (p_hold_ops) // R15
    else $error("operand changed during move");

  property p_done_pos;
    @(posedge clk) disable iff (!rstn || !ce)
    chif.done_ev |-> pos == tgt && state == apm_pkg::ST_IDLE;
  endproperty
  a_done_pos: assert property (p_done_pos) // R18
    else $error("done without reaching target");

  c_done: cover property (@(posedge clk) disable iff (!rstn)
    $rose(chif.done_ev));
endmodule // apm_channel

//--- hw/apm_top.sv
// Absolute one-speed positioning block with register port
// Operation
// R1: Target is a signed absolute count, 16 or 32 bits wide.
// R2: Software keeps 16-bit targets within -32768 to +32767.
// R3: Software keeps 32-bit targets within -999999 to +999999.
// R4: Software keeps 16-bit rates within 10 to 32767 Hz.
// R5: 32-bit rates up to 200000 Hz adapter, 100000 Hz built-in.
// R6: Built-in channels 0 to 2 where fitted; adapter channels 0 to 3.
// R7: Adapter channels 2 and 3 need the second adapter present.
// R8: Adapter channels use direction outputs 4 to 7 in order. The code drives whichever output 0 to 7 the command names.
// R9: Built-in pulse channels take built-in direction outputs. The code drives whichever output 0 to 7 the command names.
// R10: Each channel owns busy, limit, activation and stop flags.
// R11: One shared done flag and one fault flag, read only.
// R12: Busy flag is read only and high while pulsing.
// R13: Stop command is writable and cleared on run to stop.
// R14: Forward when target above position, else reverse.
// R15: Operand changes during a move wait for next activation.
// R16: Removing activation stops the move without done.
// R17: Limit in travel direction stops move and sets fault.
// R18: Stop at target, drop busy, set done.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module apm_top #(
  parameter int unsigned NCH = apm_pkg::NCH
) (
  input  wire logic        CLK,       // 200 MHz clock
  input  wire logic        RSTN,      // Sync reset, low
  input  wire logic        CE,        // Clock enable
  input  wire logic [7:0]  ADDR,      // Register byte address
  input  wire logic [31:0] WDATA,     // Write data
  input  wire logic        WR,        // Write strobe
  input  wire logic        RD,        // Read strobe
  output logic      [31:0] RDATA,     // Read data, next cycle
  output logic             IRQ,       // Level interrupt
  output logic [NCH-1:0]   PULSE_OUT, // Pulse trains
  output logic [7:0]       DIR_OUT    // Direction outputs
);
  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic [apm_pkg::CTRL_W-1:0] ctrl;
  logic signed [31:0]         target_position_operand;
  logic [31:0]                pulse_rate_operand;
  logic [1:0]                 pulse_channel_operand;
  logic [2:0]                 direction_output_operand;
  logic                       act;
  logic                       act_q;
  logic                       run_q;
  logic [NCH-1:0]             fwd_limit;
  logic [NCH-1:0]             rev_limit;
  logic [NCH-1:0]             stop_cmd;
  logic [NCH-1:0]             busy;
  logic [NCH-1:0]             pulse;
  logic [NCH-1:0]             dirs;
  logic [NCH-1:0]             done_ev;
  logic [NCH-1:0]             fault_ev;
  logic [NCH-1:0]             start;
  logic [NCH-1:0]             move_active;
  logic signed [31:0]         pos [NCH];
  logic [2:0]                 dsel [NCH];
  logic                       move_done_flag;
  logic                       move_fault_flag;
  logic                       started;
  logic [1:0]                 run_ch;
  logic [1:0]                 irq_stat;
  logic [1:0]                 irq_mask;
  logic                       act_rise;
  logic                       ch_ok;
  logic                       accept;
  logic                       reject;
  logic                       run_fall;
  logic signed [31:0]         eff_target;
  logic [7:0]                 next_dir;
  logic [31:0]                next_rdata;

  assign act_rise = act && !act_q;
  assign run_fall = run_q && !ctrl[apm_pkg::CTRL_RUN];

  // ----------------------------------------
  // Channel acceptance
  // ----------------------------------------
  always_comb begin
    ch_ok = 1'b1;
    // R6: built-in or adapter channel set
    // R7: upper adapter channels need a second adapter
    unique case (pulse_channel_operand)
      2'd2: ch_ok = ctrl[apm_pkg::CTRL_ADPT] ?
                    ctrl[apm_pkg::CTRL_ADPT2] :
                    ctrl[apm_pkg::CTRL_CH2FIT];
      2'd3: ch_ok = ctrl[apm_pkg::CTRL_ADPT] &&
                    ctrl[apm_pkg::CTRL_ADPT2];
      default: ch_ok = 1'b1;
    endcase
  end

  assign accept = act_rise && ch_ok && !busy[pulse_channel_operand];
  assign reject = act_rise && !accept;

  // R1: 16-bit targets are sign extended
  assign eff_target = ctrl[apm_pkg::CTRL_WIDE] ? target_position_operand :
    32'(signed'(target_position_operand[apm_pkg::SHORT_W-1:0]));

  // ----------------------------------------
  // Per-channel generators
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      apm_ch_if chi ();
      assign start[gi] = accept && pulse_channel_operand == 2'(gi);
      assign chi.start   = start[gi];
      assign chi.target  = eff_target;
      assign chi.rate    = pulse_rate_operand;
      // R16: activation removal winds down own channel
      assign chi.abort   = stop_cmd[gi] ||
                           (run_ch == 2'(gi) && !act);
      // R10: each channel has its own flag set
      assign chi.fwd_lim = fwd_limit[gi];
      assign chi.rev_lim = rev_limit[gi];
      assign busy[gi]     = chi.busy;
      assign pulse[gi]    = chi.pulse;
      assign dirs[gi]     = chi.dir;
      assign done_ev[gi]  = chi.done_ev;
      assign fault_ev[gi] = chi.fault_ev;
      assign pos[gi]      = chi.pos;
      assign move_active[gi] = started && run_ch == 2'(gi);
      apm_channel #(
        .HALF (apm_pkg::HALF_CLK)
      ) u_ch (
        .clk  (CLK),
        .rstn (RSTN),
        .ce   (CE),
        .chif (chi.ch)
      );
    end
  endgenerate

  assign PULSE_OUT = pulse;

  // ----------------------------------------
  // Software-written registers
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ctrl                     <= '0;
      target_position_operand  <= '0;
      pulse_rate_operand       <= '0;
      pulse_channel_operand    <= '0;
      direction_output_operand <= '0;
      act                      <= 1'b0;
      fwd_limit                <= '0;
      rev_limit                <= '0;
      irq_mask                 <= '0;
    end else if (CE && WR) begin
      unique case (ADDR)
        apm_pkg::REG_CTRL:
          ctrl <= WDATA[apm_pkg::CTRL_W-1:0];
        apm_pkg::REG_TARGET:
          target_position_operand <= signed'(WDATA);
        apm_pkg::REG_RATE:
          pulse_rate_operand <= WDATA;
        apm_pkg::REG_CMD: begin
          pulse_channel_operand <= WDATA[apm_pkg::CMD_CH_LSB +: 2];
          direction_output_operand <= WDATA[apm_pkg::CMD_DIR_LSB +: 3];
          act <= WDATA[apm_pkg::CMD_ACT];
        end
        apm_pkg::REG_LIMIT: begin
          fwd_limit <= WDATA[NCH-1:0];
          rev_limit <= WDATA[apm_pkg::LIM_REV_LSB +: NCH];
        end
        apm_pkg::REG_IRQ_MASK:
          irq_mask <= WDATA[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Stop command flags
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      stop_cmd <= '0;
      run_q    <= 1'b0;
    end else if (CE) begin
      run_q <= ctrl[apm_pkg::CTRL_RUN];
      // R13: run to stop clears, ahead of a write
      if (run_fall) begin
        stop_cmd <= '0;
      end else if (WR && ADDR == apm_pkg::REG_STOP) begin
        stop_cmd <= WDATA[NCH-1:0];
      end
    end
  end

  // ----------------------------------------
  // Activation tracking
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      act_q   <= 1'b0;
      started <= 1'b0;
      run_ch  <= '0;
    end else if (CE) begin
      act_q <= act;
      if (accept) begin
        started <= 1'b1;
        run_ch  <= pulse_channel_operand;
      end else if (!act) begin
        started <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      for (int i = 0; i < NCH; i++) begin
        dsel[i] <= '0;
      end
    end else if (CE) begin
      for (int i = 0; i < NCH; i++) begin
        if (start[i]) begin
          dsel[i] <= direction_output_operand;
        end
      end
    end
  end

  // ----------------------------------------
  // Shared done and fault flags
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      move_done_flag  <= 1'b0;
      move_fault_flag <= 1'b0;
    end else if (CE) begin
      // R11: hardware only, new events win over clear
      // R18: completion sets done
      if (|done_ev) begin
        move_done_flag <= 1'b1;
      end else if (accept) begin
        move_done_flag <= 1'b0;
      end
      // R17: limit stop sets fault at its end
      if (|fault_ev || reject) begin
        move_fault_flag <= 1'b1;
      end else if (accept) begin
        move_fault_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Direction outputs
  // ----------------------------------------
  always_comb begin
    next_dir = '0;
    for (int i = 0; i < NCH; i++) begin
      if (busy[i] && dirs[i]) begin
        next_dir[dsel[i]] = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      DIR_OUT <= '0;
    end else if (CE) begin
      DIR_OUT <= next_dir;
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      irq_stat <= '0;
    end else if (CE) begin
      for (int b = 0; b < 2; b++) begin
        if ((b == apm_pkg::IRQ_DONE && |done_ev) ||
            (b == apm_pkg::IRQ_FAULT && (|fault_ev || reject))) begin
          irq_stat[b] <= 1'b1;
        end else if (RD && ADDR == apm_pkg::REG_IRQ_STAT) begin
          irq_stat[b] <= 1'b0;
        end
      end
    end
  end

  assign IRQ = |(irq_stat & irq_mask);

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb begin
    next_rdata = '0;
    unique case (ADDR)
      apm_pkg::REG_CTRL:     next_rdata[apm_pkg::CTRL_W-1:0] = ctrl;
      apm_pkg::REG_TARGET:   next_rdata = target_position_operand;
      apm_pkg::REG_RATE:     next_rdata = pulse_rate_operand;
      apm_pkg::REG_CMD: begin
        next_rdata[apm_pkg::CMD_CH_LSB +: 2] = pulse_channel_operand;
        next_rdata[apm_pkg::CMD_DIR_LSB +: 3] = direction_output_operand;
        next_rdata[apm_pkg::CMD_ACT] = act;
      end
      apm_pkg::REG_LIMIT: begin
        next_rdata[NCH-1:0] = fwd_limit;
        next_rdata[apm_pkg::LIM_REV_LSB +: NCH] = rev_limit;
      end
      apm_pkg::REG_STOP:     next_rdata[NCH-1:0] = stop_cmd;
      apm_pkg::REG_STATUS: begin
        next_rdata[apm_pkg::ST_DONE]  = move_done_flag;
        next_rdata[apm_pkg::ST_FAULT] = move_fault_flag;
        next_rdata[apm_pkg::ST_BUSY_LSB +: NCH] = busy;
        next_rdata[apm_pkg::ST_ACTV_LSB +: NCH] = move_active;
      end
      apm_pkg::REG_IRQ_STAT: next_rdata[1:0] = irq_stat;
      apm_pkg::REG_IRQ_MASK: next_rdata[1:0] = irq_mask;
      default: begin
        for (int i = 0; i < NCH; i++) begin
          if (ADDR == apm_pkg::REG_POS0 + 8'(i) * apm_pkg::REG_STEP) begin
            next_rdata = pos[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      RDATA <= '0;
    end else if (CE) begin
      RDATA <= RD ? next_rdata : '0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_wide_target;
    @(posedge CLK) disable iff (!RSTN || !CE)
    !ctrl[apm_pkg::CTRL_WIDE] |->
      eff_target == {{16{target_position_operand[15]}},
                     target_position_operand[15:0]};
  endproperty
  a_wide_target: assert property (p_wide_target) // R1
    else $error("short target not sign extended");

  property p_ch3_gate;
    @(posedge CLK) disable iff (!RSTN || !CE)
    act_rise && pulse_channel_operand == 2'd3 &&
      !ctrl[apm_pkg::CTRL_ADPT2] |=> move_fault_flag && !started;
  endproperty
  a_ch3_gate: assert property (p_ch3_gate) // R7
    else $error("channel 3 taken without second adapter");

  property p_ch2_builtin;
    @(posedge CLK) disable iff (!RSTN || !CE)
    act_rise && pulse_channel_operand == 2'd2 &&
      !ctrl[apm_pkg::CTRL_ADPT] && !ctrl[apm_pkg::CTRL_CH2FIT]
      |-> !start[2];
  endproperty
  a_ch2_builtin: assert property (p_ch2_builtin) // R6
    else $error("unfitted channel 2 started");

  property p_stop_clear;
    @(posedge CLK) disable iff (!RSTN || !CE)
    run_fall |=> stop_cmd == '0;
  endproperty
  a_stop_clear: assert property (p_stop_clear) // R13
    else $error("stop command kept after run to stop");

  property p_abort_nodone;
    @(posedge CLK) disable iff (!RSTN || !CE)
    $fell(act) && busy[run_ch] && !move_done_flag && !(|done_ev)
      |=> !move_done_flag [*4];
  endproperty
  a_abort_nodone: assert property (p_abort_nodone) // R16
    else $error("done set after activation removed");

  property p_fault_set;
    @(posedge CLK) disable iff (!RSTN || !CE)
    |fault_ev |=> move_fault_flag && irq_stat[apm_pkg::IRQ_FAULT];
  endproperty
  a_fault_set: assert property (p_fault_set) // R17
    else $error("limit stop without fault flag");

  property p_done_set;
    @(posedge CLK) disable iff (!RSTN || !CE)
    |done_ev |=> move_done_flag ##1 (move_done_flag || $past(accept));
  endproperty
  a_done_set: assert property (p_done_set) // R18
    else $error("completion not flagged");

  property p_flags_ro;
    @(posedge CLK) disable iff (!RSTN || !CE)
    WR && ADDR == apm_pkg::REG_STATUS && !(|done_ev) && !(|fault_ev)
      && !act_rise |=> $stable(move_done_flag) && $stable(move_fault_flag);
  endproperty
  a_flags_ro: assert property (p_flags_ro) // R11
    else $error("status flag changed by a write");

  property p_active_own;
    @(posedge CLK) disable iff (!RSTN || !CE)
    accept |=> move_active == NCH'(1) << $past(pulse_channel_operand);
  endproperty
  a_active_own: assert property (p_active_own) // R10
    else $error("activation flag on wrong channel");

  c_fault: cover property (@(posedge CLK) disable iff (!RSTN)
    $rose(move_fault_flag));
  c_abort: cover property (@(posedge CLK) disable iff (!RSTN)
    $fell(act) && |busy);
  c_irq: cover property (@(posedge CLK) disable iff (!RSTN) $rose(IRQ));
endmodule // apm_top

//--- test/apm_drive_model.sv
// Drive model that counts pulse and direction input
`timescale 1ns/1ps
module apm_drive_model (
  input  wire logic        clk,  // System clock
  input  wire logic        rstn, // Sync reset, low
  input  wire logic        step, // Pulse train
  input  wire logic        dir,  // High = forward
  output logic signed [31:0] pos // Counted position
);
  logic step_q;
  always_ff @(posedge clk) begin
    step_q <= step;
    if (!rstn) begin
      pos <= '0;
    end else if (step && !step_q) begin
      pos <= dir ? pos + 1 : pos - 1;
    end
  end
endmodule // apm_drive_model

//--- test/tb_top.sv
// Self-checking bench for the positioning block
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, e); end end
module tb_top;
  logic               clk = 0;
  logic               rstn = 0;
  logic               wr = 0;
  logic               rd = 0;
  logic [7:0]         addr = '0;
  logic [31:0]        wdata = '0;
  logic [31:0]        rdata;
  logic [31:0]        d;
  logic               irq;
  logic [3:0]         pulse;
  logic [7:0]         dir;
  logic signed [31:0] pos0;
  logic signed [31:0] pos1;
  int                 n_fail = 0;
  int                 n_checks = 0;
  apm_top i_dut (.CLK(clk), .RSTN(rstn), .CE(1'b1), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq),
    .PULSE_OUT(pulse), .DIR_OUT(dir));
  apm_drive_model i_m0 (.clk(clk), .rstn(rstn), .step(pulse[0]),
    .dir(dir[4]), .pos(pos0));
  apm_drive_model i_m1 (.clk(clk), .rstn(rstn), .step(pulse[1]),
    .dir(dir[5]), .pos(pos1));
  initial forever #2.5 clk = ~clk;
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic end_sim;
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Poll status until masked bits match
  task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
    int i;
    for (i = 0; i < 4000; i++) begin
      rd_reg(apm_pkg::REG_STATUS);
      if ((d & m) === v) break;
    end
    if (i == 4000) begin
      n_fail++;
      $display("CHECK FAILED %0t status wait timed out", $time);
      end_sim();
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(apm_pkg::REG_STATUS);
    `CHK(d, 32'h0000_0000)
    wr_reg(apm_pkg::REG_CTRL, 32'h0000_000F);
    wr_reg(apm_pkg::REG_IRQ_MASK, 32'h0000_0003);
    wr_reg(apm_pkg::REG_RATE, 32'h0003_0D40);
    wr_reg(apm_pkg::REG_TARGET, 32'h0000_0003);
    wr_reg(apm_pkg::REG_CMD, 32'h0000_0140);
    wait_st(32'h0000_0010, 32'h0000_0010);
    wr_reg(apm_pkg::REG_TARGET, 32'h0000_0064);
    wait_st(32'h0000_0013, 32'h0000_0001);
    `CHK(pos0, 32'h0000_0003)
    rd_reg(apm_pkg::REG_POS0);
    `CHK(d, 32'h0000_0003)
    `CHK(irq, 1'b1)
    rd_reg(apm_pkg::REG_IRQ_STAT);
    `CHK(d, 32'h0000_0001)
    `CHK(irq, 1'b0)
    // Reverse move on the second channel
    wr_reg(apm_pkg::REG_CMD, 32'h0000_0000);
    wr_reg(apm_pkg::REG_TARGET, 32'hFFFF_FFFE);
    wr_reg(apm_pkg::REG_CMD, 32'h0000_0151);
    wait_st(32'h0000_0020, 32'h0000_0020);
    `CHK(dir[5], 1'b0)
    wait_st(32'h0000_0023, 32'h0000_0001);
    `CHK(pos1, 32'hFFFF_FFFE)
    rd_reg(apm_pkg::REG_POS0 + apm_pkg::REG_STEP);
    `CHK(d, 32'hFFFF_FFFE)
    // Forward limit mid-move
    wr_reg(apm_pkg::REG_CMD, 32'h0000_0000);
    wr_reg(apm_pkg::REG_TARGET, 32'h0000_000A);
    wr_reg(apm_pkg::REG_CMD, 32'h0000_0140);
    wait_st(32'h0000_0010, 32'h0000_0010);
    `CHK(dir[4], 1'b1)
    wr_reg(apm_pkg::REG_LIMIT, 32'h0000_0001);
    wait_st(32'h0000_0013, 32'h0000_0002);
    rd_reg(apm_pkg::REG_IRQ_STAT);
    `CHK(d, 32'h0000_0003)
    rd_reg(apm_pkg::REG_POS0);
    `CHK(d, pos0)
    // Activation removed mid-move
    wr_reg(apm_pkg::REG_LIMIT, 32'h0000_0000);
    wr_reg(apm_pkg::REG_CMD, 32'h0000_0000);
    wr_reg(apm_pkg::REG_CMD, 32'h0000_0140);
    wait_st(32'h0000_0010, 32'h0000_0010);
    wr_reg(apm_pkg::REG_CMD, 32'h0000_0000);
    wait_st(32'h0000_0011, 32'h0000_0000);
    // Refused channel 3, then a short-form move
    wr_reg(apm_pkg::REG_CTRL, 32'h0000_0005);
    wr_reg(apm_pkg::REG_CMD, 32'h0000_0173);
    wr_reg(apm_pkg::REG_STATUS, 32'h0000_0001);
    rd_reg(apm_pkg::REG_STATUS);
    `CHK(d, 32'h0000_0002)
    `CHK(irq, 1'b1)
    wr_reg(apm_pkg::REG_CMD, 32'h0000_0000);
    wr_reg(apm_pkg::REG_RATE, 32'h0000_7FFF);
    wr_reg(apm_pkg::REG_TARGET, 32'h0001_0002);
    wr_reg(apm_pkg::REG_CMD, 32'h0000_0140);
    wait_st(32'h0000_0010, 32'h0000_0010);
    `CHK(dir[4], 1'b0)
    wait_st(32'h0000_0013, 32'h0000_0001);
    `CHK(pos0, 32'h0000_0002)
    rd_reg(apm_pkg::REG_POS0);
    `CHK(d, 32'h0000_0002)
    // Stop command cleared on run to stop
    wr_reg(apm_pkg::REG_STOP, 32'h0000_000F);
    rd_reg(apm_pkg::REG_STOP);
    `CHK(d, 32'h0000_000F)
    wr_reg(apm_pkg::REG_CTRL, 32'h0000_000E);
    rd_reg(apm_pkg::REG_STOP);
    `CHK(d, 32'h0000_0000)
    rd_reg(8'hFC);
    `CHK(d, 32'h0000_0000)
    end_sim();
  end
endmodule // tb_top
